//--- hw/dbgsys_pkg.sv
package dbgsys_pkg;
    // Register indexes; the byte address on the bus is four times the index.
    localparam logic [29:0] IDX_RST_STAT = 30'h0000_0740;
    localparam logic [29:0] IDX_OSC_CTL  = 30'h0000_0742;
    localparam logic [29:0] IDX_OSC_TUNE = 30'h0000_0744;
    localparam logic [29:0] IDX_PER_OFF1 = 30'h0000_0770;
    localparam logic [29:0] IDX_PER_OFF2 = 30'h0000_0772;
    localparam logic [29:0] IDX_DBG_RX  = 30'h0000_0780;
    localparam logic [29:0] IDX_DBG_TX  = 30'h0000_0782;
    localparam logic [29:0] IDX_DBG_ST  = 30'h0000_0784;
    localparam logic [29:0] IDX_CFG_OSC = 30'h00F8_0000;
    localparam logic [29:0] IDX_CFG_WDT = 30'h00F8_0002;
    localparam logic [29:0] IDX_CFG_BOR = 30'h00F8_0004;
    localparam logic [29:0] IDX_CFG_GS  = 30'h00F8_000A;
    // Reset-and-status register layout.
    localparam logic [15:0] RST_STAT_POR     = 16'h0001;
    localparam logic [15:0] RST_STAT_WR_MASK = 16'hDFFF;
    localparam logic [15:0] RST_STAT_CTL_MSK = 16'h1F20;
    localparam logic [3:0]  RST_STAT_EVT_POS [6] = '{4'h7, 4'h6, 4'h4, 4'h1, 4'hF, 4'hE};
    localparam int          EVT_BOR      = 3;
    // Oscillator control layout.
    localparam logic [15:0] OSC_CTL_WR_MASK  = 16'h07CB;
    localparam int          OSC_CTL_CUR_LO   = 12;
    localparam int          OSC_CTL_NEW_LO   = 8;
    localparam int          CFG_FOS_LO       = 8;
    localparam logic [15:0] OSC_TUNE_WR_MASK = 16'h000F;
    localparam logic [15:0] OSC_TUNE_RST     = 16'h0000;
    localparam logic [15:0] PMD_RST        = 16'h0000;
    // Reserved configuration bits: the BOR and GS bits always read as one, the upper byte as zero.
    localparam logic [15:0] CFG_BOR_RSVD = 16'h0700;
    localparam logic [15:0] CFG_GS_RSVD  = 16'h0004;
    localparam logic [7:0]  CFG_HI_ZERO  = 8'h00;
    // Debug resources.
    localparam logic [12:0] DBG_RAM_BYTES = 13'h0050;
    localparam logic [3:0]  DBG_WORD_LAST = 4'hF;
    localparam logic [4:0]  DBG_TX_BITS   = 5'h10;
    localparam int          RX_VALID_BIT  = 16;
    localparam logic [1:0]  CFG_WAIT      = 2'h3;
    localparam int          STRAP_W       = 67;
endpackage

//--- hw/dbgsys_top.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
// What this block does
// - While debug is on, the low 80 data RAM bytes and the two pins of the chosen pair are kept from the application.
// - Exactly one of four debug pin pairs is chosen by configuration and only that pair carries debug traffic.
// - In the chosen pair one pin is the two-way data line and the other the debug clock, used for commands and data.
// - The primary pair sits on the programming data and clock pins, so a 5-pin hookup is enough for it.
// - Reserved bits of the BOR and GS configuration words always read as one; the upper byte of every word reads as zero.
// - The reset-and-status register takes a reset value that depends on the kind of reset.
// - Oscillator control takes a reset value derived from the configuration bits; tuning resets to zero.
// - Each configuration word is a 24-bit location whose lower 16 bits hold the data.
module dbgsys_top
    import dbgsys_pkg::*;
(
    // APB slave.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Programmed configuration words and debug straps.
    input  wire logic [15:0] cfg_osc_word,
    input  wire logic [15:0] cfg_wdt_word,
    input  wire logic [15:0] cfg_bor_word,
    input  wire logic [15:0] cfg_gs_word,
    input  wire logic        dbg_enable_strap,
    input  wire logic [1:0]  dbg_pair_strap,
    // Non-power-on reset causes: ext, sw, wdt, bor, trap, iopuwr.
    input  wire logic [5:0]  reset_event,
    // Debug link; pair 0 shares the programming pins.
    input  wire logic        debug_clock_line,
    input  wire logic [3:0]  debug_data_line_in,
    output logic      [3:0]  debug_data_line_out,
    output logic      [3:0]  debug_data_line_oe,
    // Resource claims toward the application.
    input  wire logic [12:0] app_ram_addr,
    output logic             app_ram_blocked,
    output logic      [3:0]  pair_claimed,
    output logic             prog_pins_shared
);
////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [STRAP_W-1:0] str1;
        logic [STRAP_W-1:0] str2;
        logic [1:0]         cfg_cnt;
        logic               cfg_done;
        logic [15:0]        cfg_osc;
        logic [15:0]        cfg_wdt;
        logic [15:0]        cfg_bor;
        logic [15:0]        cfg_gs;
        logic               dbg_en;
        logic [1:0]         dbg_pair;
        logic [5:0]         evt1;
        logic [5:0]         evt2;
        logic [5:0]         evt3;
        logic [15:0]        rst_stat;
        logic [15:0]        osc_ctl;
        logic [15:0]        osc_tune;
        logic [15:0]        per_off1;
        logic [15:0]        per_off2;
        logic [15:0]        tx_word;
        logic               tx_tgl;
        logic               rxt1;
        logic               rxt2;
        logic               rxt3;
        logic [15:0]        rx_word;
        logic               rx_valid;
        logic [31:0]        prdata;
        logic               pslverr;
        logic               ram_blk;
        logic [3:0]         claim;
        logic               share;
    } dbgsys_sys_t;

    typedef struct packed {
        logic               en1;
        logic               en2;
        logic [1:0]         sel1;
        logic [1:0]         sel2;
        logic               txt1;
        logic               txt2;
        logic               txt3;
        logic [15:0]        rx_sh;
        logic [3:0]         rx_cnt;
        logic [15:0]        rx_word;
        logic               rx_tgl;
        logic [15:0]        tx_sh;
        logic [4:0]         tx_cnt;
        logic [3:0]         dout;
        logic [3:0]         doe;
    } dbgsys_link_t;

    dbgsys_sys_t  s_q, s_d;
    dbgsys_link_t l_q, l_d;
    logic         setup_ph;
    logic         access_ph;
    logic         hit;
    logic [31:0]  rd_val;
    logic [29:0]  idx;

    assign idx       = paddr[31:2];
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;

////////////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped or misaligned addresses answer with an error.
    always_comb begin
        hit    = (paddr[1:0] == 2'h0);
        rd_val = 32'h0000_0000;
        case (idx)
            IDX_RST_STAT: rd_val[15:0] = s_q.rst_stat;
            IDX_OSC_CTL:  rd_val[15:0] = s_q.osc_ctl;
            IDX_OSC_TUNE: rd_val[15:0] = s_q.osc_tune;
            IDX_PER_OFF1: rd_val[15:0] = s_q.per_off1;
            IDX_PER_OFF2: rd_val[15:0] = s_q.per_off2;
            IDX_DBG_RX:  rd_val[16:0] = {s_q.rx_valid, s_q.rx_word};
            IDX_DBG_TX:  rd_val[15:0] = s_q.tx_word;
            IDX_DBG_ST:  rd_val[2:0]  = {s_q.dbg_pair, s_q.dbg_en};
            IDX_CFG_OSC: rd_val[23:0] = {CFG_HI_ZERO, s_q.cfg_osc};
            IDX_CFG_WDT: rd_val[23:0] = {CFG_HI_ZERO, s_q.cfg_wdt};
            IDX_CFG_BOR: rd_val[23:0] = {CFG_HI_ZERO, s_q.cfg_bor | CFG_BOR_RSVD};
            IDX_CFG_GS:  rd_val[23:0] = {CFG_HI_ZERO, s_q.cfg_gs | CFG_GS_RSVD};
            default:     hit = 1'b0;
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
    // System-clock side: straps, registers, bus and the link crossing.
    always_comb begin
        logic wr;
        logic [15:0] wd;
        logic [15:0] evt_set;
        wr      = 1'b0;
        wd      = pwdata[15:0];
        evt_set = 16'h0000;
        s_d     = s_q;
        s_d.str1 = {cfg_osc_word, cfg_wdt_word, cfg_bor_word, cfg_gs_word, dbg_enable_strap, dbg_pair_strap};
        s_d.str2 = s_q.str1;
        s_d.evt1 = reset_event;
        s_d.evt2 = s_q.evt1;
        s_d.evt3 = s_q.evt2;
        s_d.rxt1 = l_q.rx_tgl;
        s_d.rxt2 = s_q.rxt1;
        s_d.rxt3 = s_q.rxt2;
        if (!s_q.cfg_done) begin
            s_d.cfg_cnt = s_q.cfg_cnt + 2'h1;
            if (s_q.cfg_cnt == CFG_WAIT) begin
                s_d.cfg_done = 1'b1;
                {s_d.cfg_osc, s_d.cfg_wdt, s_d.cfg_bor, s_d.cfg_gs} = s_q.str2[STRAP_W-1:3];
                {s_d.dbg_en, s_d.dbg_pair} = s_q.str2[2:0];
                s_d.osc_ctl = 16'h0000;
                s_d.osc_ctl[OSC_CTL_CUR_LO+:3] = s_q.str2[3+48+CFG_FOS_LO+:3];
                s_d.osc_ctl[OSC_CTL_NEW_LO+:3] = s_q.str2[3+48+CFG_FOS_LO+:3];
                s_d.osc_tune = OSC_TUNE_RST;
            end
        end
        if (setup_ph) begin
            s_d.prdata  = pwrite ? 32'h0000_0000 : rd_val;
            s_d.pslverr = !hit;
        end
        wr = access_ph && pwrite && hit;
        if (wr) begin
            case (idx)
                IDX_RST_STAT: s_d.rst_stat = (s_q.rst_stat & ~RST_STAT_WR_MASK) | (wd & RST_STAT_WR_MASK);
                IDX_OSC_CTL:  s_d.osc_ctl  = (s_q.osc_ctl & ~OSC_CTL_WR_MASK) | (wd & OSC_CTL_WR_MASK);
                IDX_OSC_TUNE: s_d.osc_tune = wd & OSC_TUNE_WR_MASK;
                IDX_PER_OFF1: s_d.per_off1 = wd;
                IDX_PER_OFF2: s_d.per_off2 = wd;
                IDX_DBG_TX: begin
                    s_d.tx_word = wd;
                    s_d.tx_tgl  = !s_q.tx_tgl;
                end
                default: s_d.per_off1 = s_q.per_off1;
            endcase
        end
        // A read of the receive word clears valid; a new word wins.
        if (access_ph && !pwrite && idx == IDX_DBG_RX) begin
            s_d.rx_valid = 1'b0;
        end
        // The receive word holds still once its toggle is seen, so it crosses as it is.
        if (s_q.rxt2 != s_q.rxt3) begin
            s_d.rx_word  = l_q.rx_word;
            s_d.rx_valid = 1'b1;
        end
        for (int i = 0; i < 6; i++) begin
            if (s_q.evt2[i] && !s_q.evt3[i]) begin
                evt_set[RST_STAT_EVT_POS[i]] = 1'b1;
            end
        end
        // Applied after the bus write, so a recorded reset cause wins over software.
        if (evt_set != 16'h0000) begin
            s_d.rst_stat = (s_d.rst_stat & ~RST_STAT_CTL_MSK & ~RST_STAT_POR) | evt_set;
        end
        if (s_q.evt2[EVT_BOR] && !s_q.evt3[EVT_BOR]) begin
            s_d.osc_ctl[OSC_CTL_CUR_LO+:3] = s_q.cfg_osc[CFG_FOS_LO+:3];
            s_d.osc_ctl[OSC_CTL_NEW_LO+:3] = s_q.cfg_osc[CFG_FOS_LO+:3];
            s_d.osc_tune = OSC_TUNE_RST;
        end
        s_d.ram_blk = s_q.dbg_en && (app_ram_addr < DBG_RAM_BYTES);
        s_d.claim   = s_q.dbg_en ? (4'h1 << s_q.dbg_pair) : 4'h0;
        s_d.share   = s_q.dbg_en && (s_q.dbg_pair == 2'h0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q        <= '0;
            s_q.rst_stat <= RST_STAT_POR;
            s_q.per_off1 <= PMD_RST;
            s_q.per_off2 <= PMD_RST;
            s_q.osc_tune <= OSC_TUNE_RST;
        end else begin
            s_q <= s_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Link side, clocked by the probe's debug clock.
    always_comb begin
        logic din;
        din      = 1'b0;
        l_d      = l_q;
        l_d.en1  = s_q.dbg_en;
        l_d.en2  = l_q.en1;
        l_d.sel1 = s_q.dbg_pair;
        l_d.sel2 = l_q.sel1;
        l_d.txt1 = s_q.tx_tgl;
        l_d.txt2 = l_q.txt1;
        l_d.txt3 = l_q.txt2;
        din = debug_data_line_in[l_q.sel2];
        if (l_q.en2 && l_q.tx_cnt == 5'h00) begin
            l_d.rx_sh  = {l_q.rx_sh[14:0], din};
            l_d.rx_cnt = l_q.rx_cnt + 4'h1;
            if (l_q.rx_cnt == DBG_WORD_LAST) begin
                l_d.rx_word = {l_q.rx_sh[14:0], din};
                l_d.rx_tgl  = !l_q.rx_tgl;
            end
        end
        if (l_q.tx_cnt != 5'h00) begin
            l_d.tx_sh  = {l_q.tx_sh[14:0], 1'b0};
            l_d.tx_cnt = l_q.tx_cnt - 5'h01;
        end
        // Receive pauses while a word goes out; the load restarts its bit count.
        // The probe's clock only runs in frames, so the load waits for its edges.
        if (l_q.txt2 != l_q.txt3 && l_q.en2) begin
            l_d.tx_sh  = s_q.tx_word;
            l_d.tx_cnt = DBG_TX_BITS;
            l_d.rx_cnt = 4'h0;
        end
        l_d.dout = (l_d.tx_cnt != 5'h00 && l_d.tx_sh[15]) ? (4'h1 << l_q.sel2) : 4'h0;
        l_d.doe  = (l_d.tx_cnt != 5'h00 && l_q.en2) ? (4'h1 << l_q.sel2) : 4'h0;
    end

    always_ff @(posedge debug_clock_line or negedge presetn) begin
        if (!presetn) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    assign prdata              = s_q.prdata;
    assign pready              = 1'b1;
    assign pslverr             = s_q.pslverr && access_ph;
    assign app_ram_blocked     = s_q.ram_blk;
    assign pair_claimed        = s_q.claim;
    assign prog_pins_shared    = s_q.share;
    assign debug_data_line_out = l_q.dout;
    assign debug_data_line_oe  = l_q.doe;

////////////////////////////////////////////////////////////////////////////////
    sequence apb_setup_s;
        psel && !penable;
    endsequence
    sequence apb_access_s;
        psel && penable;
    endsequence

    pslverr_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_setup_s ##1 apb_access_s) |-> (pslverr == ($past(paddr[1:0]) != 2'h0 || !$past(hit))))
        else $error("Error answer does not match decode.");

    cfg_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_setup_s and (!pwrite && paddr[31:2] == IDX_CFG_BOR && paddr[1:0] == 2'h0)) ##1 apb_access_s
        |-> (prdata[10:8] == 3'h7 && prdata[23:16] == 8'h00))
        else $error("Reserved configuration bits not read as one.");

    gs_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_setup_s and (!pwrite && paddr[31:2] == IDX_CFG_GS && paddr[1:0] == 2'h0)) ##1 apb_access_s
        |-> prdata[2])
        else $error("Reserved code segment bit not read as one.");

    ram_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (app_ram_blocked == ($past(s_q.dbg_en) && $past(app_ram_addr) < DBG_RAM_BYTES)))
        else $error("Debug RAM guard wrong.");

    pair_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.dbg_en ##1 s_q.dbg_en |-> $onehot(pair_claimed))
        else $error("Debug pair claim not one-hot.");

    release_a: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.dbg_en ##1 !s_q.dbg_en |-> (pair_claimed == 4'h0 && !app_ram_blocked && !prog_pins_shared))
        else $error("Resources held while debug is off.");

    share_a: assert property (@(posedge pclk) disable iff (!presetn)
        prog_pins_shared |-> pair_claimed == 4'h1)
        else $error("Programming pins shared by an alternate pair.");

    reset_control_status_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(s_q.evt2[0])) |=> (s_q.rst_stat[7] && !s_q.rst_stat[0] && s_q.rst_stat[12] == 1'b0))
        else $error("External reset not recorded in status.");

    por_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (|(s_q.evt2 & ~s_q.evt3)) |=> !s_q.rst_stat[0])
        else $error("Power-on flag kept after another reset.");

    osc_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_q.cfg_done) |-> (s_q.osc_ctl[14:12] == s_q.cfg_osc[10:8] && s_q.osc_tune == 16'h0000))
        else $error("Oscillator reset value not from configuration.");

    rx_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.rxt2 != s_q.rxt3) |=> s_q.rx_valid)
        else $error("Received word not flagged valid.");

    tx_oe_a: assert property (@(posedge debug_clock_line) disable iff (!presetn)
        $rose(l_q.tx_cnt == DBG_TX_BITS) |-> (l_q.doe != 4'h0)[*8])
        else $error("Debug data line released mid-word.");

endmodule

//--- verification/dbgsys_probe.sv
`timescale 1ns/100ps
module dbgsys_probe (
    // Link pins.
    output logic            dclk,
    output logic      [3:0] dout,
    input  wire logic [3:0] line,
    input  wire logic [3:0] dev_oe,
    // Chosen pair.
    input  wire logic [1:0] pair
);
    initial begin
        dclk = 1'b0;
        dout = 4'h0;
    end
    // The clock only runs inside frames.
    task automatic tick;
        #6 dclk = 1'b1;
        #6 dclk = 1'b0;
    endtask
    // Word goes MSB first on the chosen pair, the inverse on the others.
    task automatic send(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            dout = {4{~w[i]}} ^ (4'h1 << pair);
            tick();
        end
        dout = ~dout;
    endtask
    // Bits are taken at the falling edge while the device drives the chosen pin.
    task automatic recv(input int n, output logic [15:0] w, output logic [7:0] cnt, output logic stray);
        w = 16'h0000;
        cnt = 8'h00;
        stray = 1'b0;
        repeat (n) begin
            tick();
            if (dev_oe[pair] === 1'b1) begin
                w = {w[14:0], line[pair]};
                cnt = cnt + 8'h01;
            end
            if ((dev_oe & ~(4'h1 << pair)) !== 4'h0) begin
                stray = 1'b1;
            end
        end
    endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/100ps
module tb
    import dbgsys_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [15:0] c_osc, c_wdt, c_bor, c_gs;
    logic en_s, shared, blocked, dclk;
    logic [1:0] pair_s;
    logic [5:0] rst_evt;
    logic [3:0] d_in, d_out, d_oe, p_out, claimed;
    logic [12:0] ram_addr;
    int n_fail, check_count;
    assign d_in = (d_oe & d_out) | (~d_oe & p_out);
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;
    dbgsys_top u_dbgsys_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg_osc_word(c_osc), .cfg_wdt_word(c_wdt), .cfg_bor_word(c_bor), .cfg_gs_word(c_gs),
        .dbg_enable_strap(en_s), .dbg_pair_strap(pair_s), .reset_event(rst_evt),
        .debug_clock_line(dclk), .debug_data_line_in(d_in), .debug_data_line_out(d_out),
        .debug_data_line_oe(d_oe), .app_ram_addr(ram_addr), .app_ram_blocked(blocked),
        .pair_claimed(claimed), .prog_pins_shared(shared));
    dbgsys_probe u_probe (.dclk(dclk), .dout(p_out), .line(d_in), .dev_oe(d_oe), .pair(pair_s));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            n_fail++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [29:0] i, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, {i, 2'b00}, 32'h0, r, e);
        chk(r, exp);
    endtask
    task automatic wr(input logic [29:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, {i, 2'b00}, d, r, e);
    endtask
    task automatic do_reset(input logic en, input logic [1:0] p);
        presetn <= 1'b0;
        en_s <= en;
        pair_s <= p;
        @(posedge pclk);
        u_probe.tick();
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        // Two link edges carry the captured enable and pair across before any frame.
        repeat (2) u_probe.tick();
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals;
        rd(IDX_RST_STAT, 32'h0000_0001);
        rd(IDX_OSC_CTL, 32'h0000_5500);
        rd(IDX_OSC_TUNE, 32'h0000_0000);
        rd(IDX_PER_OFF1, 32'h0000_0000);
        rd(IDX_PER_OFF2, 32'h0000_0000);
        rd(IDX_CFG_OSC, 32'h0000_0500);
        rd(IDX_CFG_WDT, 32'h0000_803F);
        rd(IDX_CFG_BOR, 32'h0000_8700);
        rd(IDX_CFG_GS, 32'h0000_0007);
    endtask
    task automatic t_bus;
        logic [31:0] r;
        logic e;
        wr(IDX_PER_OFF1, 32'h0000_FFFF);
        wr(IDX_CFG_GS, 32'h0000_0000);
        wr(IDX_OSC_TUNE, 32'h0000_FFFF);
        rd(IDX_PER_OFF1, 32'h0000_FFFF);
        rd(IDX_CFG_GS, 32'h0000_0007);
        rd(IDX_OSC_TUNE, 32'h0000_000F);
        apb(1'b0, 32'h0000_0400, 32'h0, r, e);
        chk({r[30:0], e}, 32'h0000_0001);
        apb(1'b1, {IDX_PER_OFF2, 2'b01}, 32'h0000_00FF, r, e);
        chk({31'h0, e}, 32'h0000_0001);
        rd(IDX_PER_OFF2, 32'h0000_0000);
    endtask
    task automatic t_events;
        logic [15:0] exp;
        exp = 16'h0001;
        for (int i = 0; i < 6; i++) begin
            @(posedge pclk);
            rst_evt <= 6'h01 << i;
            repeat (3) @(posedge pclk);
            rst_evt <= 6'h00;
            repeat (6) @(posedge pclk);
            exp = (exp | (16'h0001 << RST_STAT_EVT_POS[i])) & 16'hFFFE;
            rd(IDX_RST_STAT, {16'h0, exp});
            if (i == EVT_BOR) begin
                rd(IDX_OSC_TUNE, 32'h0);
            end
        end
    endtask
    task automatic t_pair(input logic [1:0] p);
        logic [15:0] w;
        logic [7:0] n;
        logic s;
        do_reset(1'b1, p);
        ram_addr <= 13'h004F;
        repeat (2) @(posedge pclk);
        chk({31'h0, blocked}, 32'h1);
        ram_addr <= 13'h0050;
        repeat (2) @(posedge pclk);
        chk({31'h0, blocked}, 32'h0);
        chk({28'h0, claimed}, 32'h1 << p);
        chk({31'h0, shared}, {31'h0, p == 2'h0});
        rd(IDX_DBG_ST, {29'h0, p, 1'b1});
        u_probe.send(16'hA5C3 ^ {14'h0, p});
        repeat (8) @(posedge pclk);
        rd(IDX_DBG_RX, {15'h0, 1'b1, 16'hA5C3 ^ {14'h0, p}});
        rd(IDX_DBG_RX, {16'h0, 16'hA5C3 ^ {14'h0, p}});
        wr(IDX_DBG_TX, {16'h0, 16'h3C5A ^ {p, 14'h0}});
        u_probe.recv(30, w, n, s);
        chk({16'h0, w}, {16'h0, 16'h3C5A ^ {p, 14'h0}});
        chk({23'h0, s, n}, 32'h10);
    endtask
    task automatic t_off;
        logic [15:0] w;
        logic [7:0] n;
        logic s;
        do_reset(1'b0, 2'h2);
        ram_addr <= 13'h0000;
        repeat (2) @(posedge pclk);
        chk({27'h0, blocked, claimed, shared}, 32'h0);
        wr(IDX_DBG_TX, 32'h0000_FFFF);
        u_probe.recv(30, w, n, s);
        chk({23'h0, s, n}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        n_fail = 0;
        check_count = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {c_osc, c_wdt, c_bor, c_gs} = {16'h0500, 16'h803F, 16'h8000, 16'h0003};
        rst_evt = 6'h00;
        ram_addr = 13'h0000;
        do_reset(1'b0, 2'h0);
        t_reset_vals();
        t_bus();
        t_events();
        for (int p = 0; p < 4; p++) begin
            t_pair(p[1:0]);
        end
        t_off();
        summarize();
    end
    initial begin
        #2000000;
        n_fail++;
        summarize();
    end
endmodule
